// ==== core/pulse_glitch_filter.sv ====
`timescale 1ns/1ns
`default_nettype none
module pulse_glitch_filter #(
  parameter int unsigned FILT_CYC = 100000
) (
  // clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // raw pin and filtered level
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [31:0] cnt;
    logic level;
  } filt_state_t;

  filt_state_t s_ff;
  filt_state_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.sync1 = din;
    nxt_s.sync2 = s_ff.sync1;
    // a new level must hold for the whole filter time before it is taken
    if (s_ff.sync2 == s_ff.level) begin
      nxt_s.cnt = 32'h0;
    end else if (s_ff.cnt >= 32'(FILT_CYC - 1)) begin
      nxt_s.level = s_ff.sync2;
      nxt_s.cnt = 32'h0;
    end else begin
      nxt_s.cnt = s_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else if (en) begin
      s_ff <= nxt_s;
    end
  end

  assign dout = s_ff.level;

  a_filter_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (en && s_ff.cnt < 32'(FILT_CYC - 1)) |=> $stable(dout))
    else $error("filtered level changed before the filter time");

endmodule // pulse_glitch_filter
`default_nettype wire

// ==== core/time_signal_input_conditioner.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "tsc_defines.svh"
module time_signal_input_conditioner #(
  parameter int unsigned WINDOW_CYC = `TSC_WINDOW_CYC,
  parameter int unsigned FILTER_CYC = `TSC_FILTER_CYC,
  parameter int unsigned SHORT_MIN_CYC = `TSC_SHORT_MIN_CYC,
  parameter int unsigned LONG_MIN_CYC = `TSC_LONG_MIN_CYC,
  parameter int unsigned LONG_MAX_CYC = `TSC_LONG_MAX_CYC
) (
  // clock, reset and enable
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // register port
  input wire tsc_pkg::reg_addr_t REG_ADDR,
  input wire tsc_pkg::reg_data_t REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output var tsc_pkg::reg_data_t REG_RDATA,
  // receiver link
  input wire logic SIG_IN,
  output logic RECEIVER_POWER_SAVE_OUTPUT,
  output logic PULLUP_EN,
  output logic RX_LED
);
  import tsc_pkg::*;

  typedef struct packed {
    logic analyse;
    logic pol_force;
    logic pol_inv;
    logic pu_force;
    logic pu_on;
    logic gate_inv;
    logic led_en;
    cond_state_t st;
    logic [31:0] win;
    logic [31:0] hi;
    logic auto_inv;
    logic pu_need;
    logic act_d;
    logic [31:0] wid;
    logic [31:0] last_wid;
    logic last_long;
    logic bad;
    logic [7:0] pcnt;
    logic led;
    logic pwr;
    logic pu;
    reg_data_t rdata;
  } cond_state_s_t;

  cond_state_s_t s_ff;
  cond_state_s_t nxt_s;
  logic filt;
  logic inv;
  logic act;
  logic running;
  logic [31:0] hi_next;
  logic win_end;
  reg_data_t rd;

  // pin synchroniser and glitch filter ahead of every consumer
  pulse_glitch_filter #(
    .FILT_CYC(FILTER_CYC)
  ) u_filter (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .en(CLK_EN),
    .din(SIG_IN),
    .dout(filt)
  );

  always_comb begin
    nxt_s = s_ff;
    rd = '0;
    // forced polarity or the detected one, both reversible by the invert bit
    inv = s_ff.pol_force ? s_ff.pol_inv : (s_ff.auto_inv ^ s_ff.pol_inv);
    act = filt ^ inv;
    running = (s_ff.st == ST_RUN);
    hi_next = s_ff.hi + {31'h0, filt};
    win_end = (s_ff.win >= 32'(WINDOW_CYC - 1));

    // register writes come first so that hardware events below win
    if (REG_WR) begin
      unique case (REG_ADDR)
        `TSC_REG_CTRL: begin
          nxt_s.analyse = REG_WDATA[`TSC_CTRL_ANALYSE];
          nxt_s.pol_force = REG_WDATA[`TSC_CTRL_POL_FORCE];
          nxt_s.pol_inv = REG_WDATA[`TSC_CTRL_POL_INV];
          nxt_s.pu_force = REG_WDATA[`TSC_CTRL_PU_FORCE];
          nxt_s.pu_on = REG_WDATA[`TSC_CTRL_PU_ON];
          nxt_s.gate_inv = REG_WDATA[`TSC_CTRL_GATE_INV];
          nxt_s.led_en = REG_WDATA[`TSC_CTRL_LED_EN];
        end
        `TSC_REG_STATUS: begin
          if (REG_WDATA[`TSC_STAT_BAD]) begin
            nxt_s.bad = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // analysis sequence: probe the pull-up need, then run
    unique case (s_ff.st)
      ST_OFF: begin
        if (s_ff.analyse) begin
          nxt_s.st = ST_PROBE;
          nxt_s.win = 32'h0;
          nxt_s.hi = 32'h0;
        end
      end
      ST_PROBE: begin
        if (!s_ff.analyse) begin
          nxt_s.st = ST_OFF;
        end else if (win_end) begin
          // an open-collector output never rises without the pull-up
          nxt_s.pu_need = (hi_next == 32'h0);
          nxt_s.st = ST_RUN;
          nxt_s.win = 32'h0;
          nxt_s.hi = 32'h0;
        end else begin
          nxt_s.win = s_ff.win + 32'h1;
          nxt_s.hi = hi_next;
        end
      end
      ST_RUN: begin
        if (!s_ff.analyse) begin
          nxt_s.st = ST_OFF;
        end else if (win_end) begin
          // the active phase is the shorter part of each second
          nxt_s.auto_inv = (hi_next > 32'(WINDOW_CYC / 2));
          nxt_s.win = 32'h0;
          nxt_s.hi = 32'h0;
        end else begin
          nxt_s.win = s_ff.win + 32'h1;
          nxt_s.hi = hi_next;
        end
      end
      default: begin
        nxt_s.st = ST_OFF;
      end
    endcase

    // pulse width measurement, width counting saturates instead of wrapping; the 8-bit pulse count wraps
    nxt_s.act_d = running & act;
    if (running && act) begin
      if (!s_ff.act_d) begin
        nxt_s.wid = 32'h1;
      end else if (s_ff.wid != 32'hFFFFFFFF) begin
        nxt_s.wid = s_ff.wid + 32'h1;
      end
    end
    if (s_ff.act_d && !(running && act)) begin
      nxt_s.last_wid = s_ff.wid;
      nxt_s.last_long = (s_ff.wid >= 32'(LONG_MIN_CYC));
      nxt_s.pcnt = s_ff.pcnt + 8'h01;
      if (s_ff.wid < 32'(SHORT_MIN_CYC) || s_ff.wid > 32'(LONG_MAX_CYC)) begin
        nxt_s.bad = 1'b1;
      end
    end

    // pin outputs, each registered
    nxt_s.led = s_ff.led_en & running & act;
    nxt_s.pwr = (s_ff.st != ST_OFF) ^ s_ff.gate_inv;
    if (s_ff.pu_force) begin
      nxt_s.pu = s_ff.pu_on;
    end else begin
      nxt_s.pu = (s_ff.st == ST_PROBE) ? 1'b0 : s_ff.pu_need;
    end

    // read data stands only in the cycle after the strobe
    nxt_s.rdata = '0;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `TSC_REG_CTRL: begin
          rd[`TSC_CTRL_ANALYSE] = s_ff.analyse;
          rd[`TSC_CTRL_POL_FORCE] = s_ff.pol_force;
          rd[`TSC_CTRL_POL_INV] = s_ff.pol_inv;
          rd[`TSC_CTRL_PU_FORCE] = s_ff.pu_force;
          rd[`TSC_CTRL_PU_ON] = s_ff.pu_on;
          rd[`TSC_CTRL_GATE_INV] = s_ff.gate_inv;
          rd[`TSC_CTRL_LED_EN] = s_ff.led_en;
        end
        `TSC_REG_STATUS: begin
          rd[`TSC_STAT_ACTIVE] = s_ff.act_d;
          rd[`TSC_STAT_AUTO_INV] = s_ff.auto_inv;
          rd[`TSC_STAT_PU_NEED] = s_ff.pu_need;
          rd[`TSC_STAT_LONG] = s_ff.last_long;
          rd[`TSC_STAT_BAD] = s_ff.bad;
          rd[`TSC_STAT_RUN] = running;
          rd[`TSC_STAT_CNT_LSB +: 8] = s_ff.pcnt;
        end
        `TSC_REG_WIDTH: begin
          rd = s_ff.last_wid;
        end
        default: begin
          rd = '0;
        end
      endcase
      nxt_s.rdata = rd;
    end
  end

  // the pull-up starts connected: safe for both output types until probed
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s_ff <= '0;
      s_ff.led_en <= 1'b1;
      s_ff.pu_need <= 1'b1;
      s_ff.pu <= 1'b1;
    end else if (CLK_EN) begin
      s_ff <= nxt_s;
    end
  end

  assign REG_RDATA = s_ff.rdata;
  assign RECEIVER_POWER_SAVE_OUTPUT = s_ff.pwr;
  assign PULLUP_EN = s_ff.pu;
  assign RX_LED = s_ff.led;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  a_auto_polarity: assert property (
    (CLK_EN && running && s_ff.analyse && win_end)
      |=> s_ff.auto_inv == ($past(hi_next) > 32'(WINDOW_CYC / 2)))
    else $error("detected polarity does not follow high time");

  a_pullup_forced: assert property (
    (CLK_EN && s_ff.pu_force) |=> PULLUP_EN == $past(s_ff.pu_on))
    else $error("forced pull-up not applied");

  a_pullup_probe: assert property (
    (CLK_EN && !s_ff.pu_force && s_ff.st == ST_PROBE) |=> !PULLUP_EN)
    else $error("pull-up not released during probe");

  a_led_pulse: assert property (
    CLK_EN |=> RX_LED == $past(s_ff.led_en && running && act))
    else $error("indicator does not mirror active pulse");

  a_led_gate: assert property (
    (CLK_EN && !s_ff.led_en) |=> !RX_LED)
    else $error("indicator lit while disabled");

  a_invert_sense: assert property (
    ($changed(s_ff.pol_inv) && $stable(filt) && $stable(s_ff.auto_inv)
      && $stable(s_ff.pol_force)) |-> act != $past(act))
    else $error("invert setting does not reverse input");

  a_power_off: assert property (
    (CLK_EN && s_ff.st == ST_OFF) [*2]
      |-> RECEIVER_POWER_SAVE_OUTPUT == $past(s_ff.gate_inv))
    else $error("receiver powered while not analysing");

  a_power_level: assert property (
    CLK_EN |=> RECEIVER_POWER_SAVE_OUTPUT
      == ($past(s_ff.st != ST_OFF) ^ $past(s_ff.gate_inv)))
    else $error("power output level wrong");

  a_supply_high: assert property (
    (CLK_EN && !s_ff.gate_inv && running) |=> RECEIVER_POWER_SAVE_OUTPUT)
    else $error("supply output low during analysis");

  a_width_class: assert property (
    (CLK_EN && s_ff.act_d && !(running && act))
      |=> s_ff.last_long == ($past(s_ff.wid) >= 32'(LONG_MIN_CYC))
        && s_ff.last_wid == $past(s_ff.wid))
    else $error("pulse width classified wrongly");

  a_bad_sticky: assert property (
    (CLK_EN && s_ff.bad && !(REG_WR && REG_ADDR == `TSC_REG_STATUS
      && REG_WDATA[`TSC_STAT_BAD])) |=> s_ff.bad)
    else $error("bad width flag lost without a clear");

  c_long_pulse: cover property (CLK_EN && s_ff.act_d && !act && running
    && s_ff.wid >= 32'(LONG_MIN_CYC));
  c_short_pulse: cover property (CLK_EN && s_ff.act_d && !act && running
    && s_ff.wid >= 32'(SHORT_MIN_CYC) && s_ff.wid < 32'(LONG_MIN_CYC));
  c_pullup_need: cover property (s_ff.st == ST_PROBE ##1 s_ff.st == ST_RUN
    && s_ff.pu_need);
  c_auto_inverted: cover property (running && s_ff.auto_inv);
  c_bad_width: cover property (running && s_ff.bad);

endmodule // time_signal_input_conditioner
`default_nettype wire

// ==== inc/tsc_defines.svh ====
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

// system clock rate and derived cycles per millisecond
`define TSC_CLK_HZ 100000000
`define TSC_CYC_PER_MS (`TSC_CLK_HZ / 1000)

// pulse timing of the receiver, in milliseconds
`define TSC_PULSE_SHORT_MS 100
`define TSC_PULSE_LONG_MS 200
`define TSC_PULSE_TOL_MS 50
`define TSC_WINDOW_MS 1000
`define TSC_FILTER_MS 1

// timing counts in system clock cycles
`define TSC_SHORT_MIN_CYC \
  ((`TSC_PULSE_SHORT_MS - `TSC_PULSE_TOL_MS) * `TSC_CYC_PER_MS)
`define TSC_LONG_MIN_CYC \
  ((`TSC_PULSE_LONG_MS - `TSC_PULSE_TOL_MS) * `TSC_CYC_PER_MS)
`define TSC_LONG_MAX_CYC \
  ((`TSC_PULSE_LONG_MS + `TSC_PULSE_TOL_MS) * `TSC_CYC_PER_MS)
`define TSC_WINDOW_CYC (`TSC_WINDOW_MS * `TSC_CYC_PER_MS)
`define TSC_FILTER_CYC (`TSC_FILTER_MS * `TSC_CYC_PER_MS)

// register byte offsets
`define TSC_REG_CTRL 4'h0
`define TSC_REG_STATUS 4'h4
`define TSC_REG_WIDTH 4'h8

// control register fields
`define TSC_CTRL_ANALYSE 0
`define TSC_CTRL_POL_FORCE 1
`define TSC_CTRL_POL_INV 2
`define TSC_CTRL_PU_FORCE 3
`define TSC_CTRL_PU_ON 4
`define TSC_CTRL_GATE_INV 5
`define TSC_CTRL_LED_EN 6
`define TSC_CTRL_RST 32'h00000040

// status register fields
`define TSC_STAT_ACTIVE 0
`define TSC_STAT_AUTO_INV 1
`define TSC_STAT_PU_NEED 2
`define TSC_STAT_LONG 3
`define TSC_STAT_BAD 4
`define TSC_STAT_RUN 5
`define TSC_STAT_CNT_LSB 8

`endif

// ==== inc/tsc_pkg.sv ====
package tsc_pkg;
  typedef logic [3:0] reg_addr_t;
  typedef logic [31:0] reg_data_t;
  typedef enum logic [1:0] {ST_OFF, ST_PROBE, ST_RUN} cond_state_t;
endpackage

// ==== sim/rx_module_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module rx_module_model #(
  parameter int unsigned PERIOD = 200
) (
  // clock and supply
  input wire logic clk,
  input wire logic pwr,
  // behaviour select
  input wire logic inv,
  input wire logic oc,
  input wire logic long_sel,
  input wire logic pu_en,
  // pin and true pulse phase
  output logic sig,
  output logic act
);
  int unsigned cnt = 0;
  logic tog = 1'b0;
  logic lvl;
  always_ff @(posedge clk) begin
    cnt <= (!pwr || cnt == PERIOD - 1) ? 0 : cnt + 1;
    tog <= ~tog;
  end
  // 20 or 40 cycles stand for the 100 or 200 ms pulse each second
  assign act = pwr && (cnt < (long_sel ? 40 : 20));
  assign lvl = act ^ inv;
  // an unpowered output clamps the line low through its own supply;
  // a released, unpulled line has no defined level: toggle every cycle
  assign sig = !pwr ? 1'b0 : ((oc && lvl) ? (pu_en | tog) : lvl);
endmodule // rx_module_model
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tsc_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, sig_in, pwr, pullup_en, rx_led;
  logic act, m_inv, m_oc, m_long, clk_en;
  reg_addr_t reg_addr;
  reg_data_t reg_wdata, reg_rdata, d;
  int fails = 0;
  int n_checks = 0;
  time_signal_input_conditioner #(.WINDOW_CYC(200), .FILTER_CYC(3),
    .SHORT_MIN_CYC(10), .LONG_MIN_CYC(30), .LONG_MAX_CYC(50))
  u_time_signal_input_conditioner (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .CLK_EN(clk_en), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .SIG_IN(sig_in), .RECEIVER_POWER_SAVE_OUTPUT(pwr),
    .PULLUP_EN(pullup_en), .RX_LED(rx_led));
  rx_module_model u_rx_module_model (.clk(clk_sys), .pwr(pwr),
    .inv(m_inv), .oc(m_oc), .long_sel(m_long), .pu_en(pullup_en),
    .sig(sig_in), .act(act));
  task automatic end_sim;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input reg_addr_t a, input reg_data_t v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input reg_addr_t a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // sample the indicator inside the next true pulse and well after it
  task automatic led_pulse(input logic e_in, input logic e_out);
    int k;
    k = 0;
    while (act === 1'b1) @(posedge clk_sys);
    while (act !== 1'b1 && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    cyc(12);
    chk(rx_led, e_in);
    cyc(60);
    chk(rx_led, e_out);
  endtask
  task automatic t_reset;
    chk({pwr, pullup_en, rx_led}, 3'b010);
    chk(reg_rdata, 32'h0);
    rd(4'h0);
    chk(d, 32'h40);
    wr(4'hC, 32'hFF);
    rd(4'hC);
    chk(d, 32'h0);
  endtask
  // a write made while the clock enable is low must be lost
  task automatic t_freeze;
    cyc(1);
    clk_en <= 1'b0;
    wr(4'h0, 32'h41);
    cyc(4);
    chk(pwr, 1'b0);
    clk_en <= 1'b1;
    rd(4'h0);
    chk(d, 32'h40);
  endtask
  task automatic t_power;
    wr(4'h0, 32'h41);
    cyc(4);
    chk(pwr, 1'b1);
    wr(4'h0, 32'h61);
    cyc(4);
    chk(pwr, 1'b0);
    wr(4'h0, 32'h60);
    cyc(4);
    chk(pwr, 1'b1);
    wr(4'h0, 32'h40);
    cyc(4);
    chk(pwr, 1'b0);
  endtask
  task automatic t_normal;
    m_long <= 1'b1;
    wr(4'h0, 32'h41);
    cyc(450);
    chk(pullup_en, 1'b0);
    led_pulse(1'b1, 1'b0);
    rd(4'h8);
    chk(d >= 38 && d <= 42, 1);
    rd(4'h4);
    chk(d[5:1], 5'b10100);
    m_long <= 1'b0;
    cyc(400);
    rd(4'h4);
    chk(d[3], 1'b0);
    wr(4'h0, 32'h01);
    led_pulse(1'b0, 1'b0);
    wr(4'h0, 32'h40);
  endtask
  task automatic t_invert;
    m_inv <= 1'b1;
    wr(4'h0, 32'h41);
    cyc(450);
    led_pulse(1'b1, 1'b0);
    rd(4'h4);
    chk(d[1], 1'b1);
    wr(4'h0, 32'h43);
    led_pulse(1'b0, 1'b1);
    rd(4'h4);
    chk(d[4], 1'b1);
    wr(4'h4, 32'h10);
    rd(4'h4);
    chk(d[4], 1'b0);
    wr(4'h0, 32'h47);
    led_pulse(1'b1, 1'b0);
    wr(4'h0, 32'h45);
    led_pulse(1'b0, 1'b1);
    wr(4'h0, 32'h40);
    m_inv <= 1'b0;
  endtask
  task automatic t_pullup;
    // let the unpowered line settle low so the probe starts clean
    cyc(20);
    m_oc <= 1'b1;
    wr(4'h0, 32'h41);
    cyc(250);
    chk(pullup_en, 1'b1);
    rd(4'h4);
    chk(d[2], 1'b1);
    led_pulse(1'b1, 1'b0);
    wr(4'h0, 32'h49);
    cyc(3);
    chk(pullup_en, 1'b0);
    wr(4'h0, 32'h59);
    cyc(3);
    chk(pullup_en, 1'b1);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // whole run needs about 3100 cycles
  initial begin
    cyc(20000);
    fails++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    m_inv = 1'b0;
    m_oc = 1'b0;
    m_long = 1'b0;
    clk_en = 1'b1;
    cyc(8);
    rst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_freeze();
    t_power();
    t_normal();
    t_invert();
    t_pullup();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
